// [src/srlx_defs.svh]
// register offsets, field positions, reset values and limits of the receive link control bank
// assumes byte-wide registers addressed by a 12-bit register address
`ifndef SRLX_DEFS_SVH
`define SRLX_DEFS_SVH

`define SRLX_ADDR_W 12
`define SRLX_DATA_W 8

`define SRLX_ADDR_GEN_CTRL 12'h300
`define SRLX_ADDR_LATENCY 12'h302
`define SRLX_ADDR_DLY_FIXED 12'h304
`define SRLX_ADDR_DLY_VAR 12'h306
`define SRLX_ADDR_SEL_01 12'h308
`define SRLX_ADDR_SEL_23 12'h309

`define SRLX_LINK_EN_BIT 0
`define SRLX_FIELD_MSB 4
`define SRLX_SEL_ODD_LSB 3
`define SRLX_SEL_EVEN_LSB 0
`define SRLX_SEL_W 3

`define SRLX_RST_LINK_EN 1'h0
`define SRLX_RST_LATENCY 5'h00
`define SRLX_RST_DLY_FIXED 5'h00
`define SRLX_RST_DLY_VAR 5'h1f
`define SRLX_RST_SEL0 3'h0
`define SRLX_RST_SEL1 3'h1
`define SRLX_RST_SEL2 3'h2
`define SRLX_RST_SEL3 3'h3

`define SRLX_CNT_MAX 5'h1f
`define SRLX_READ_UNMAPPED 8'h00

`endif

// [src/srlx_pkg.sv]
// types shared by the receive link control bank and its lane crossbar
// widths of 3 and 5 bits are written here directly; srlx_defs.svh is not included
`default_nettype none
package srlx_pkg;
    typedef logic [2:0] srlx_sel_t;
    typedef logic [4:0] srlx_dly_t;
    typedef enum {meas_idle, meas_run} srlx_meas_state_t;
endpackage : srlx_pkg
`default_nettype wire

// [src/srlx_xbar_if.sv]
// lane source selections passed from the register bank to the crossbar
// assumes srlx_pkg is compiled first
`timescale 1ns/100ps
`default_nettype none
interface srlx_xbar_if #(parameter int NUM_LANES = 4);
    import srlx_pkg::*;
    srlx_sel_t sel [NUM_LANES];
    modport ctrl (output sel);
    modport xbar (input sel);
endinterface : srlx_xbar_if
`default_nettype wire

// [src/srlx_lane_xbar.sv]
// crossbar routing deserialized physical inputs onto logical lanes, one register stage
// assumes input words are already on the parallel clock
`timescale 1ns/100ps
`default_nettype none
module srlx_lane_xbar #(
    parameter int NUM_INPUTS = 8,
    parameter int NUM_LANES = 4,
    parameter int DATA_W = 32
) (
    input wire logic clock,
    input wire logic rst,
    srlx_xbar_if.xbar xb,
    input wire logic [NUM_INPUTS*DATA_W-1:0] serial_input_data,
    output logic [NUM_LANES*DATA_W-1:0] lane_data
);
    import srlx_pkg::*;

    // unselectable codes give zeros
    function automatic logic [DATA_W-1:0] pick(input logic [NUM_INPUTS*DATA_W-1:0] din, input srlx_sel_t s);
        logic [DATA_W-1:0] r;
        r = '0;
        if (int'(s) < NUM_INPUTS) begin
            r = din[int'(s)*DATA_W +: DATA_W];
        end
        return r;
    endfunction : pick

    for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
        always_ff @(posedge clock) begin
            if (rst) begin
                lane_data[l*DATA_W +: DATA_W] <= '0;
            end else begin
                lane_data[l*DATA_W +: DATA_W] <= pick(serial_input_data, xb.sel[l]);
            end
        end
    end
endmodule : srlx_lane_xbar
`default_nettype wire

// [src/srlx_rx_link_ctrl.sv]
// receive link control bank: bring-up bit, latency measurement, multiframe delays, lane crossbar
// assumes all inputs are on the parallel clock, one register request per cycle at most
`timescale 1ns/100ps
`default_nettype none
`include "srlx_defs.svh"
module srlx_rx_link_ctrl #(
    parameter int NUM_INPUTS = 8,
    parameter int NUM_LANES = 4,
    parameter int DATA_W = 32
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    input wire logic global_lmfc,
    input wire logic deframer_lmfc,
    input wire logic [NUM_INPUTS*DATA_W-1:0] serial_input_data,
    output logic [NUM_LANES*DATA_W-1:0] lane_data,
    output logic link_enable,
    output srlx_pkg::srlx_dly_t global_multiframe_delay,
    output srlx_pkg::srlx_dly_t buffer_readout_point,
    output logic delayed_global_lmfc,
    output logic buffer_release
);
    import srlx_pkg::*;

    if (NUM_INPUTS < 1 || NUM_INPUTS > 8) begin : g_chk_in
        $error("NUM_INPUTS must be 1 to 8");
    end
    if (NUM_LANES != 4) begin : g_chk_ln
        $error("NUM_LANES must be 4");
    end
    if (DATA_W < 1) begin : g_chk_w
        $error("DATA_W must be positive");
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic link_en_ff;
    srlx_dly_t measured_link_latency_ff;
    srlx_dly_t global_multiframe_delay_ff;
    srlx_dly_t buffer_readout_point_ff;
    srlx_sel_t sel_ff [NUM_LANES];
    logic [7:0] reg_rdata_ff;
    logic reg_ack_ff;

    srlx_xbar_if #(.NUM_LANES(NUM_LANES)) xb ();

    function automatic logic [7:0] sel_pair(input srlx_sel_t odd, input srlx_sel_t even);
        return {2'h0, odd, even};
    endfunction : sel_pair

    always_ff @(posedge clock) begin
        if (rst) begin
            link_en_ff <= `SRLX_RST_LINK_EN;
        end else if (reg_wr && reg_addr == `SRLX_ADDR_GEN_CTRL) begin
            link_en_ff <= reg_wdata[`SRLX_LINK_EN_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            global_multiframe_delay_ff <= `SRLX_RST_DLY_FIXED;
            buffer_readout_point_ff <= `SRLX_RST_DLY_VAR;
        end else if (reg_wr) begin
            if (reg_addr == `SRLX_ADDR_DLY_FIXED) begin
                global_multiframe_delay_ff <= reg_wdata[`SRLX_FIELD_MSB:0];
            end
            // no clamp above ten: software keeps to that limit
            if (reg_addr == `SRLX_ADDR_DLY_VAR) begin
                buffer_readout_point_ff <= reg_wdata[`SRLX_FIELD_MSB:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sel_ff[0] <= `SRLX_RST_SEL0;
            sel_ff[1] <= `SRLX_RST_SEL1;
            sel_ff[2] <= `SRLX_RST_SEL2;
            sel_ff[3] <= `SRLX_RST_SEL3;
        end else if (reg_wr) begin
            if (reg_addr == `SRLX_ADDR_SEL_01) begin
                sel_ff[1] <= reg_wdata[`SRLX_SEL_ODD_LSB +: `SRLX_SEL_W];
                sel_ff[0] <= reg_wdata[`SRLX_SEL_EVEN_LSB +: `SRLX_SEL_W];
            end
            if (reg_addr == `SRLX_ADDR_SEL_23) begin
                sel_ff[3] <= reg_wdata[`SRLX_SEL_ODD_LSB +: `SRLX_SEL_W];
                sel_ff[2] <= reg_wdata[`SRLX_SEL_EVEN_LSB +: `SRLX_SEL_W];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_LANES; i++) begin
            xb.sel[i] = sel_ff[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read port

    logic [7:0] nxt_reg_rdata;

    always_comb begin
        case (reg_addr)
            `SRLX_ADDR_GEN_CTRL: nxt_reg_rdata = {7'h00, link_en_ff};
            `SRLX_ADDR_LATENCY: nxt_reg_rdata = {3'h0, measured_link_latency_ff};
            `SRLX_ADDR_DLY_FIXED: nxt_reg_rdata = {3'h0, global_multiframe_delay_ff};
            `SRLX_ADDR_DLY_VAR: nxt_reg_rdata = {3'h0, buffer_readout_point_ff};
            `SRLX_ADDR_SEL_01: nxt_reg_rdata = sel_pair(sel_ff[1], sel_ff[0]);
            `SRLX_ADDR_SEL_23: nxt_reg_rdata = sel_pair(sel_ff[3], sel_ff[2]);
            default: nxt_reg_rdata = `SRLX_READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
            reg_ack_ff <= 1'b0;
        end else begin
            reg_ack_ff <= reg_wr | reg_rd;
            if (reg_rd) begin
                reg_rdata_ff <= nxt_reg_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dynamic latency: cycles from global multiframe edge to deframer edge

    srlx_meas_state_t meas_state_ff;
    srlx_dly_t meas_cnt_ff;

    always_ff @(posedge clock) begin
        if (rst) begin
            meas_state_ff <= meas_idle;
            meas_cnt_ff <= 5'h00;
            measured_link_latency_ff <= `SRLX_RST_LATENCY;
        end else if (!link_en_ff) begin
            meas_state_ff <= meas_idle;
            meas_cnt_ff <= 5'h00;
        end else begin
            case (meas_state_ff)
                meas_idle: begin
                    if (global_lmfc && deframer_lmfc) begin
                        measured_link_latency_ff <= 5'h00;
                    end else if (global_lmfc) begin
                        meas_state_ff <= meas_run;
                        meas_cnt_ff <= 5'h01;
                    end
                end
                meas_run: begin
                    if (deframer_lmfc) begin
                        measured_link_latency_ff <= meas_cnt_ff;
                        meas_state_ff <= meas_idle;
                    end else if (meas_cnt_ff != `SRLX_CNT_MAX) begin
                        meas_cnt_ff <= meas_cnt_ff + 5'h01;
                    end
                end
                default: begin
                    meas_state_ff <= meas_idle;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fixed delay on the global multiframe clock

    logic dly_act_ff;
    srlx_dly_t dly_cnt_ff;
    logic delayed_global_lmfc_ff;

    always_ff @(posedge clock) begin
        if (rst) begin
            dly_act_ff <= 1'b0;
            dly_cnt_ff <= 5'h00;
            delayed_global_lmfc_ff <= 1'b0;
        end else begin
            delayed_global_lmfc_ff <= 1'b0;
            if (global_lmfc) begin
                dly_act_ff <= 1'b1;
                dly_cnt_ff <= global_multiframe_delay_ff;
            end else if (dly_act_ff) begin
                if (dly_cnt_ff == 5'h00) begin
                    delayed_global_lmfc_ff <= 1'b1;
                    dly_act_ff <= 1'b0;
                end else begin
                    dly_cnt_ff <= dly_cnt_ff - 5'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // elastic buffer release point within the receive multiframe

    srlx_dly_t pos_ff;
    srlx_dly_t nxt_pos;
    logic buffer_release_ff;

    always_comb begin
        if (deframer_lmfc) begin
            nxt_pos = 5'h00;
        end else if (pos_ff == `SRLX_CNT_MAX) begin
            nxt_pos = pos_ff;
        end else begin
            nxt_pos = pos_ff + 5'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pos_ff <= `SRLX_CNT_MAX;
            buffer_release_ff <= 1'b0;
        end else begin
            pos_ff <= nxt_pos;
            buffer_release_ff <= link_en_ff && nxt_pos == buffer_readout_point_ff
                && (deframer_lmfc || pos_ff != `SRLX_CNT_MAX);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lane crossbar and outputs

    srlx_lane_xbar #(
        .NUM_INPUTS(NUM_INPUTS),
        .NUM_LANES(NUM_LANES),
        .DATA_W(DATA_W)
    ) u_xbar (
        .clock(clock),
        .rst(rst),
        .xb(xb.xbar),
        .serial_input_data(serial_input_data),
        .lane_data(lane_data)
    );

    assign link_enable = link_en_ff;
    assign global_multiframe_delay = global_multiframe_delay_ff;
    assign buffer_readout_point = buffer_readout_point_ff;
    assign delayed_global_lmfc = delayed_global_lmfc_ff;
    assign buffer_release = buffer_release_ff;
    assign reg_rdata = reg_rdata_ff;
    assign reg_ack = reg_ack_ff;
endmodule : srlx_rx_link_ctrl
`default_nettype wire

// [tb/srlx_rx_link_ctrl_properties.sv]
// port checker of the receive link control bank
// assumes a bind from the bench top, one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "srlx_defs.svh"
module srlx_rx_link_ctrl_properties
    import srlx_pkg::*;
#(
    parameter int NUM_INPUTS = 8,
    parameter int NUM_LANES = 4,
    parameter int DATA_W = 32
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic global_lmfc,
    input wire logic deframer_lmfc,
    input wire logic [NUM_INPUTS*DATA_W-1:0] serial_input_data,
    input wire logic [NUM_LANES*DATA_W-1:0] lane_data,
    input wire logic link_enable,
    input wire srlx_pkg::srlx_dly_t global_multiframe_delay,
    input wire srlx_pkg::srlx_dly_t buffer_readout_point,
    input wire logic delayed_global_lmfc,
    input wire logic buffer_release
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    a_enable_write: assert property (reg_wr && reg_addr == `SRLX_ADDR_GEN_CTRL |=>
        link_enable == $past(reg_wdata[0])) else $error("enable bit not written");
    a_fixed_write: assert property (reg_wr && reg_addr == `SRLX_ADDR_DLY_FIXED |=>
        global_multiframe_delay == $past(reg_wdata[4:0])) else $error("fixed delay not written");
    a_var_write: assert property (reg_wr && reg_addr == `SRLX_ADDR_DLY_VAR |=>
        buffer_readout_point == $past(reg_wdata[4:0])) else $error("readout point not written");
    a_fixed_read: assert property (reg_rd && reg_addr == `SRLX_ADDR_DLY_FIXED |=>
        reg_rdata == {3'h0, $past(global_multiframe_delay)}) else $error("fixed delay read wrong");
    a_var_read: assert property (reg_rd && reg_addr == `SRLX_ADDR_DLY_VAR |=>
        reg_rdata == {3'h0, $past(buffer_readout_point)}) else $error("readout point read wrong");
    a_latency_rsvd: assert property (reg_rd && reg_addr == `SRLX_ADDR_LATENCY |=>
        reg_ack && reg_rdata[7:5] == 3'h0) else $error("latency read wrong");
    a_delay_zero: assert property (global_lmfc && global_multiframe_delay == 5'h00 ##1 !global_lmfc |=>
        delayed_global_lmfc) else $error("zero delay pulse late");
    a_release_zero: assert property (deframer_lmfc && link_enable && buffer_readout_point == 5'h00
        |=> buffer_release) else $error("release at point zero late");
    a_release_gated: assert property ((!link_enable)[*2] |-> !buffer_release)
        else $error("release while link off");
endmodule : srlx_rx_link_ctrl_properties
`default_nettype wire

// [tb/srlx_tx_model.sv]
// transmit-side stand-in: lane words and multiframe pulses
// assumes eight inputs of 32 bits, pulse called after a rising edge
`timescale 1ns/100ps
`default_nettype none
module srlx_tx_model (
    output logic [255:0] serial_input_data,
    output logic global_lmfc,
    output logic deframer_lmfc,
    input wire logic clock
);
    logic [23:0] cnt_ff = 24'h000000;
    initial begin
        global_lmfc = 1'b0;
        deframer_lmfc = 1'b0;
        serial_input_data = '0;
    end
    ////////////////////////////////////////
    // word carries its input number and changes every cycle
    always @(posedge clock) begin
        cnt_ff <= #1 cnt_ff + 24'h000001;
        for (int n = 0; n < 8; n++) serial_input_data[n*32+:32] <= #1 {8'(n), cnt_ff};
    end
    // one-cycle pulses, returns just after the edge that samples them
    task automatic pulse(input logic g, input logic d);
        @(posedge clock);
        #1;
        global_lmfc = g;
        deframer_lmfc = d;
        @(posedge clock);
        #1;
        global_lmfc = 1'b0;
        deframer_lmfc = 1'b0;
    endtask : pulse
endmodule : srlx_tx_model
`default_nettype wire

// [tb/test_serial_rx_latency_lane_xbar.sv]
// bench of the receive link control bank
// assumes the transmit stand-in and the bound port checker
`timescale 1ns/100ps
`default_nettype none
`include "srlx_defs.svh"
module test_serial_rx_latency_lane_xbar;
    import srlx_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, rd_ff;
    logic reg_ack, global_lmfc, deframer_lmfc, link_enable, delayed_global_lmfc, buffer_release;
    logic [255:0] serial_input_data;
    logic [127:0] lane_data;
    srlx_dly_t global_multiframe_delay, buffer_readout_point;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    srlx_tx_model tx_u (.clock(clock), .serial_input_data(serial_input_data), .global_lmfc(global_lmfc),
        .deframer_lmfc(deframer_lmfc));
    srlx_rx_link_ctrl dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .global_lmfc(global_lmfc),
        .deframer_lmfc(deframer_lmfc), .serial_input_data(serial_input_data), .lane_data(lane_data),
        .link_enable(link_enable), .global_multiframe_delay(global_multiframe_delay),
        .buffer_readout_point(buffer_readout_point), .delayed_global_lmfc(delayed_global_lmfc),
        .buffer_release(buffer_release));
    initial forever #50 clock = ~clock;
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic reg_op(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        chk("ack", 1, reg_ack);
        rd_ff = reg_rdata;
    endtask : reg_op
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        reg_op(0, a, 8'h00);
        chk($sformatf("reg %h", a), e, rd_ff);
    endtask : rd_chk
    // edges after the sampling edge until the chosen pulse shows
    task automatic wait_cnt(input logic rel, output int n);
        n = 0;
        #1;
        while ((rel ? buffer_release : delayed_global_lmfc) !== 1'b1 && n < 40) begin
            @(posedge clock);
            #2;
            n++;
        end
    endtask : wait_cnt
    task automatic t_reset;
        rd_chk(`SRLX_ADDR_GEN_CTRL, 8'h00);
        rd_chk(`SRLX_ADDR_LATENCY, 8'h00);
        rd_chk(`SRLX_ADDR_DLY_FIXED, 8'h00);
        rd_chk(`SRLX_ADDR_DLY_VAR, 8'h1f);
        rd_chk(`SRLX_ADDR_SEL_01, 8'h08);
        rd_chk(`SRLX_ADDR_SEL_23, 8'h1a);
        rd_chk(12'h30a, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_xbar;
        logic [255:0] w;
        for (int n = 0; n < 8; n++) begin
            reg_op(1, `SRLX_ADDR_SEL_01, {2'h0, 3'(7 - n), 3'(n)});
            reg_op(1, `SRLX_ADDR_SEL_23, {2'h0, 3'(n), 3'(n)});
            rd_chk(`SRLX_ADDR_SEL_01, {2'h0, 3'(7 - n), 3'(n)});
            @(posedge clock);
            #2;
            w = serial_input_data;
            @(posedge clock);
            #2;
            chk("lane0", w[n*32+:32], lane_data[31:0]);
            chk("lane1", w[(7-n)*32+:32], lane_data[63:32]);
            chk("lane2", w[n*32+:32], lane_data[95:64]);
            chk("lane3", w[n*32+:32], lane_data[127:96]);
        end
        $display("test crossbar done");
    endtask : t_xbar
    task automatic t_latency;
        int k [3] = '{3, 0, 40};
        int e [3] = '{3, 0, 31};
        reg_op(1, `SRLX_ADDR_DLY_FIXED, 8'h00);
        reg_op(1, `SRLX_ADDR_DLY_VAR, 8'h0a);
        reg_op(1, `SRLX_ADDR_GEN_CTRL, 8'h01);
        for (int i = 0; i < 3; i++) begin
            if (k[i] == 0) begin
                tx_u.pulse(1, 1);
            end else begin
                tx_u.pulse(1, 0);
                repeat (k[i] - 2) @(posedge clock);
                tx_u.pulse(0, 1);
            end
            rd_chk(`SRLX_ADDR_LATENCY, 8'(e[i]));
        end
        reg_op(1, `SRLX_ADDR_LATENCY, 8'h15);
        rd_chk(`SRLX_ADDR_LATENCY, 8'h1f);
        $display("test latency done");
    endtask : t_latency
    task automatic t_delays;
        int d [3] = '{0, 4, 31};
        int p [3] = '{0, 2, 10};
        int n;
        for (int i = 0; i < 3; i++) begin
            reg_op(1, `SRLX_ADDR_DLY_FIXED, 8'(d[i]));
            tx_u.pulse(1, 0);
            wait_cnt(0, n);
            chk("delay", d[i] + 1, n);
            reg_op(1, `SRLX_ADDR_DLY_VAR, 8'(p[i]));
            tx_u.pulse(0, 1);
            wait_cnt(1, n);
            chk("release", p[i], n);
        end
        reg_op(1, `SRLX_ADDR_GEN_CTRL, 8'h00);
        tx_u.pulse(0, 1);
        wait_cnt(1, n);
        chk("release off", 40, n);
        $display("test delays done");
    endtask : t_delays
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        #1;
        rst = 1'b0;
        t_reset();
        t_xbar();
        t_latency();
        t_delays();
        // mid-run reset must bring every field back to its default
        @(posedge clock);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        t_reset();
        final_report();
    end
endmodule : test_serial_rx_latency_lane_xbar
bind srlx_rx_link_ctrl srlx_rx_link_ctrl_properties #(.NUM_INPUTS(NUM_INPUTS), .NUM_LANES(NUM_LANES),
    .DATA_W(DATA_W)) props_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .global_lmfc(global_lmfc),
    .deframer_lmfc(deframer_lmfc), .serial_input_data(serial_input_data), .lane_data(lane_data),
    .link_enable(link_enable), .global_multiframe_delay(global_multiframe_delay),
    .buffer_readout_point(buffer_readout_point), .delayed_global_lmfc(delayed_global_lmfc),
    .buffer_release(buffer_release));
`default_nettype wire
